// ---- shared/dbfc_regs.svh ----
// Purpose: Command codes, unlock addresses and timing counts for the flash host sequencer
// Assumes: Word-mode unlock addresses; byte mode uses the doubled addresses
// Notes:   Definitions only
`ifndef DBFC_REGS_SVH
`define DBFC_REGS_SVH

// ----------------------------------------------------------------
// Command data
// ----------------------------------------------------------------
`define DBFC_CMD_RESET     8'hf0
`define DBFC_CMD_UNLOCK1   8'haa
`define DBFC_CMD_UNLOCK2   8'h55
`define DBFC_CMD_IDENT     8'h90
`define DBFC_CMD_PROGRAM   8'ha0
`define DBFC_CMD_BYPASS    8'h20
`define DBFC_CMD_ERASE     8'h80
`define DBFC_CMD_CHIP      8'h10
`define DBFC_CMD_SECURE    8'h88
`define DBFC_CMD_EXIT2     8'h00

// ----------------------------------------------------------------
// Unlock addresses, word and byte mode
// ----------------------------------------------------------------
`define DBFC_ADDR_U1_W     12'h555
`define DBFC_ADDR_U2_W     12'h2aa
`define DBFC_ADDR_U1_B     12'haaa
`define DBFC_ADDR_U2_B     12'h555

// ----------------------------------------------------------------
// Identification read offsets
// ----------------------------------------------------------------
`define DBFC_ID_MAKER      8'h00
`define DBFC_ID_PART_W     8'h01
`define DBFC_ID_PART_B     8'h02
`define DBFC_ID_PROT_W     8'h02
`define DBFC_ID_PROT_B     8'h04
`define DBFC_PROT_SET      8'h01

// ----------------------------------------------------------------
// Bus timing, 20 MHz clock
// ----------------------------------------------------------------
`define DBFC_CLK_NS        50
`define DBFC_T_WE_NS       100
`define DBFC_T_HOLD_NS     50
`define DBFC_T_RD_NS       100
`define DBFC_T_WE_CYC      ((`DBFC_T_WE_NS + `DBFC_CLK_NS - 1) / `DBFC_CLK_NS)
`define DBFC_T_HOLD_CYC    ((`DBFC_T_HOLD_NS + `DBFC_CLK_NS - 1) / `DBFC_CLK_NS)
`define DBFC_T_RD_CYC      ((`DBFC_T_RD_NS + `DBFC_CLK_NS - 1) / `DBFC_CLK_NS)
// Edges a pin change needs to cross the two-flop synchroniser
`define DBFC_SYNC_CYC      2

`endif

// ---- shared/dbfc_pkg.sv ----
// Purpose: Types for the flash host sequencer
// Assumes: Used with dbfc_regs.svh
// Notes:   Nothing here is imported; use dbfc_pkg::name
package dbfc_pkg;

  // ----------------------------------------------------------------
  // Operations a user may order
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    DBFC_OP_RESET,
    DBFC_OP_IDENT,
    DBFC_OP_SEC_ENTER,
    DBFC_OP_SEC_EXIT,
    DBFC_OP_PROGRAM,
    DBFC_OP_BYP_ENTER,
    DBFC_OP_BYP_PROGRAM,
    DBFC_OP_BYP_EXIT,
    DBFC_OP_CHIP_ERASE,
    DBFC_OP_READ
  } dbfc_op_t;

  // ----------------------------------------------------------------
  // One bus write cycle
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [21:0] addr;
    logic [15:0] data;
  } dbfc_cycle_t;

  // ----------------------------------------------------------------
  // User request
  // ----------------------------------------------------------------
  typedef struct packed {
    dbfc_op_t    op;
    logic        bank;
    logic [21:0] addr;
    logic [15:0] data;
  } dbfc_req_t;

endpackage

// ---- hw/dbfc_host.sv ----
// Purpose: Host sequencer that drives a dual-bank NOR flash through its parallel pins
// Assumes: Flash pins are asynchronous; ready_busy_n is synchronised here
// Notes:   One request at a time, no queue
// Summary of operation
// RULE_01: Reset command is one write, any address.
// RULE_02: Reset mid erase setup; ignored once erasing.
// RULE_03: Reset mid program setup; ignored once programming.
// RULE_04: Identification mode left only by reset.
// RULE_05: After failure flag, reset returns read mode.
// RULE_06: Ident: two unlocks, then bank address 90h.
// RULE_07: No ident while other bank busy.
// RULE_08: Ident reads maker at 00, part 01/02.
// RULE_09: Protect read at sector offset 02/04.
// RULE_10: Ident reads repeat without re-entry.
// RULE_11: Secure region: three in, four out.
// RULE_12: No secure access during embedded ops.
// RULE_13: Program: two unlocks, A0h, address/data.
// RULE_14: Completion reported on ready_busy_n.
// RULE_15: Commands ignored while programming.
// RULE_16: Program only clears bits.
// RULE_17: Bypass entry 20h; bypass program two writes.
// RULE_18: Bypass accepts only program and exit.
// RULE_19: Bypass exit: bank 90h then 00h.
// RULE_20: High voltage on accel pin enters bypass.
// RULE_21: Chip erase is six writes.
// RULE_22: Commands ignored during chip erase.
// RULE_23: Address held across falling, data across rising.
// RULE_24: Flash reads array after power-up.
// RULE_25: Host never writes misordered cycles.
// RULE_26: Each bank keeps own sequence state.
// RULE_27: Unexpected write abandons unlock sequence.
`timescale 1ns/1ps
`include "dbfc_regs.svh"

module dbfc_host #(
  parameter int ADDR_W = 22,
  parameter int DATA_W = 16,
  parameter int BANK_MSB = 21
) (
  input  wire logic               mclk,
  input  wire logic               reset_n,
  input  wire logic               req_valid,
  output logic                    req_ready,
  input  wire dbfc_pkg::dbfc_req_t req,
  input  wire logic               byte_mode,
  input  wire logic               accel_req,
  output logic                    rd_valid,
  output logic [DATA_W-1:0]       rd_data,
  output logic                    busy,
  output logic                    bypass_active,
  output logic                    ident_active,
  output logic                    secure_active,
  output logic [ADDR_W-1:0]       flash_addr,
  output logic [DATA_W-1:0]       flash_dq_o,
  output logic                    flash_dq_oe,
  input  wire logic [DATA_W-1:0]  flash_dq_i,
  output logic                    flash_ce_n,
  output logic                    flash_we_n,
  output logic                    flash_oe_n,
  output logic                    flash_byte_n,
  output logic                    protect_accel_pin,
  input  wire logic               ready_busy_n
);

  // ----------------------------------------------------------------
  // Synchronisers
  // ----------------------------------------------------------------
  logic [1:0]        rb_sync_q;
  logic [DATA_W-1:0] dq_s1_q, dq_s2_q;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rb_sync_q <= 2'h3;
      dq_s1_q   <= '0;
      dq_s2_q   <= '0;
    end else begin
      rb_sync_q <= {rb_sync_q[0], ready_busy_n};
      dq_s1_q   <= flash_dq_i;
      dq_s2_q   <= dq_s1_q;
    end
  end

  wire logic flash_ready = rb_sync_q[1];

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    DBFC_ST_IDLE, DBFC_ST_SETUP, DBFC_ST_STROBE, DBFC_ST_HOLD,
    DBFC_ST_READ, DBFC_ST_WAIT
  } dbfc_state_t;

  dbfc_state_t              state_q, state_d;
  dbfc_pkg::dbfc_cycle_t    seq_q [6];
  dbfc_pkg::dbfc_cycle_t    seq_d [6];
  logic [2:0]               len_q, len_d, idx_q, idx_d;
  logic [2:0]               cnt_q, cnt_d;
  logic                     embed_q, embed_d;
  logic                     byp_q, byp_d, id_q, id_d, sec_q, sec_d;
  logic                     rdv_q, rdv_d;
  logic [DATA_W-1:0]        rdd_q, rdd_d;
  logic [ADDR_W-1:0]        ba;
  logic [ADDR_W-1:0]        u1, u2;

  always_comb begin
    ba = '0;
    ba[BANK_MSB] = req.bank;
    // Both unlock addresses carry the target bank; cycles built from req.addr use that address as given
    u1 = ba | (byte_mode ? ADDR_W'(`DBFC_ADDR_U1_B) : ADDR_W'(`DBFC_ADDR_U1_W)); // see RULE_26
    u2 = ba | (byte_mode ? ADDR_W'(`DBFC_ADDR_U2_B) : ADDR_W'(`DBFC_ADDR_U2_W));
  end

  assign req_ready = (state_q == DBFC_ST_IDLE); // see RULE_07

  function automatic dbfc_pkg::dbfc_cycle_t cyc(logic [ADDR_W-1:0] a, logic [7:0] d);
    cyc.addr = a;
    cyc.data = DATA_W'(d);
  endfunction

  always_comb begin
    state_d = state_q;
    seq_d   = seq_q;
    len_d   = len_q;
    idx_d   = idx_q;
    cnt_d   = cnt_q;
    embed_d = embed_q;
    byp_d   = byp_q | accel_req;                         // see RULE_20
    id_d    = id_q;
    sec_d   = sec_q;
    rdv_d   = 1'b0;
    rdd_d   = rdd_q;
    unique case (state_q)
      DBFC_ST_IDLE: begin
        if (req_valid) begin
          idx_d   = '0;
          embed_d = 1'b0;
          seq_d[0] = cyc(u1, `DBFC_CMD_UNLOCK1);         // see RULE_26
          seq_d[1] = cyc(u2, `DBFC_CMD_UNLOCK2);         // see RULE_25
          unique case (req.op)
            dbfc_pkg::DBFC_OP_RESET: begin
              seq_d[0] = cyc(req.addr, `DBFC_CMD_RESET); // see RULE_01
              len_d = 3'd1;
              id_d  = 1'b0;                              // see RULE_04
            end
            dbfc_pkg::DBFC_OP_IDENT: begin
              seq_d[2] = cyc(ba | u1, `DBFC_CMD_IDENT);  // see RULE_06
              len_d = 3'd3;
              id_d  = 1'b1;
            end
            dbfc_pkg::DBFC_OP_SEC_ENTER: begin
              seq_d[2] = cyc(u1, `DBFC_CMD_SECURE);      // see RULE_11
              len_d = 3'd3;
              sec_d = 1'b1;
            end
            dbfc_pkg::DBFC_OP_SEC_EXIT: begin
              seq_d[2] = cyc(u1, `DBFC_CMD_IDENT);
              seq_d[3] = cyc(req.addr, `DBFC_CMD_EXIT2);
              len_d = 3'd4;
              sec_d = 1'b0;
            end
            dbfc_pkg::DBFC_OP_PROGRAM: begin
              seq_d[2] = cyc(u1, `DBFC_CMD_PROGRAM);     // see RULE_13
              seq_d[3] = '{addr: req.addr, data: req.data};
              len_d = 3'd4;
              embed_d = 1'b1;
            end
            dbfc_pkg::DBFC_OP_BYP_ENTER: begin
              seq_d[2] = cyc(u1, `DBFC_CMD_BYPASS);      // see RULE_17
              len_d = 3'd3;
              byp_d = 1'b1;
            end
            dbfc_pkg::DBFC_OP_BYP_PROGRAM: begin
              seq_d[0] = cyc(req.addr, `DBFC_CMD_PROGRAM); // see RULE_18
              seq_d[1] = '{addr: req.addr, data: req.data};
              len_d = 3'd2;
              embed_d = 1'b1;
            end
            dbfc_pkg::DBFC_OP_BYP_EXIT: begin
              seq_d[0] = cyc(ba, `DBFC_CMD_IDENT);       // see RULE_19
              seq_d[1] = cyc(req.addr, `DBFC_CMD_EXIT2);
              len_d = 3'd2;
              byp_d = accel_req;
            end
            dbfc_pkg::DBFC_OP_CHIP_ERASE: begin
              seq_d[2] = cyc(u1, `DBFC_CMD_ERASE);       // see RULE_21
              seq_d[3] = cyc(u1, `DBFC_CMD_UNLOCK1);
              seq_d[4] = cyc(u2, `DBFC_CMD_UNLOCK2);
              seq_d[5] = cyc(u1, `DBFC_CMD_CHIP);
              len_d = 3'd6;
              embed_d = 1'b1;
            end
            dbfc_pkg::DBFC_OP_READ: begin
              seq_d[0] = '{addr: req.addr, data: '0};    // see RULE_10
              len_d = 3'd1;
            end
            default: len_d = 3'd1;
          endcase
          cnt_d   = 3'(`DBFC_T_HOLD_CYC);
          state_d = (req.op == dbfc_pkg::DBFC_OP_READ) ? DBFC_ST_READ : DBFC_ST_SETUP;
          // Read data must also cross the synchroniser before capture
          if (req.op == dbfc_pkg::DBFC_OP_READ) cnt_d = 3'(`DBFC_T_RD_CYC + `DBFC_SYNC_CYC);
        end
      end
      DBFC_ST_SETUP: begin                               // see RULE_23
        cnt_d   = 3'(`DBFC_T_WE_CYC);
        state_d = DBFC_ST_STROBE;
      end
      DBFC_ST_STROBE: begin
        cnt_d = cnt_q - 3'd1;
        if (cnt_q == 3'd1) begin
          cnt_d   = 3'(`DBFC_T_HOLD_CYC);
          state_d = DBFC_ST_HOLD;
        end
      end
      DBFC_ST_HOLD: begin
        cnt_d = cnt_q - 3'd1;
        if (cnt_q <= 3'd1) begin
          idx_d = idx_q + 3'd1;
          if (idx_q + 3'd1 == len_q) begin
            idx_d   = '0;
            // Busy reaches flash_ready only after the synchroniser
            cnt_d   = 3'(`DBFC_SYNC_CYC);
            state_d = embed_q ? DBFC_ST_WAIT : DBFC_ST_IDLE; // see RULE_15
          end else begin
            state_d = DBFC_ST_SETUP;
          end
        end
      end
      DBFC_ST_READ: begin                                // see RULE_08
        cnt_d = cnt_q - 3'd1;
        if (cnt_q <= 3'd1) begin
          rdv_d   = 1'b1;
          rdd_d   = dq_s2_q;
          state_d = DBFC_ST_IDLE;
        end
      end
      DBFC_ST_WAIT: begin                                // see RULE_14
        if (flash_ready && cnt_q == 3'd0) begin
          state_d = DBFC_ST_IDLE;
        end
        if (cnt_q != 3'd0) cnt_d = cnt_q - 3'd1;
      end
      default: state_d = DBFC_ST_IDLE;
    endcase
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= DBFC_ST_IDLE;
      for (int i = 0; i < 6; i++) seq_q[i] <= '0;
      len_q   <= '0;
      idx_q   <= '0;
      cnt_q   <= '0;
      embed_q <= 1'b0;
      byp_q   <= 1'b0;
      id_q    <= 1'b0;
      sec_q   <= 1'b0;
      rdv_q   <= 1'b0;
      rdd_q   <= '0;
    end else begin
      state_q <= state_d;
      seq_q   <= seq_d;
      len_q   <= len_d;
      idx_q   <= idx_d;
      cnt_q   <= cnt_d;
      embed_q <= embed_d;
      byp_q   <= byp_d;
      id_q    <= id_d;
      sec_q   <= sec_d;
      rdv_q   <= rdv_d;
      rdd_q   <= rdd_d;
    end
  end

  // ----------------------------------------------------------------
  // Pin drive
  // ----------------------------------------------------------------
  dbfc_pkg::dbfc_cycle_t cur;
  assign cur = seq_q[idx_q];

  assign flash_addr        = cur.addr;
  assign flash_dq_o        = cur.data;
  assign flash_dq_oe       = (state_q == DBFC_ST_SETUP) || (state_q == DBFC_ST_STROBE)
                             || (state_q == DBFC_ST_HOLD);
  assign flash_ce_n        = !(flash_dq_oe || state_q == DBFC_ST_READ);
  assign flash_we_n        = (state_q != DBFC_ST_STROBE);
  assign flash_oe_n        = (state_q != DBFC_ST_READ);
  assign flash_byte_n      = !byte_mode;
  assign protect_accel_pin = accel_req;
  assign rd_valid          = rdv_q;
  assign rd_data           = rdd_q;
  assign busy              = (state_q == DBFC_ST_WAIT);
  assign bypass_active     = byp_q;
  assign ident_active      = id_q;
  assign secure_active     = sec_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_we_data_held: assert property (@(posedge mclk) disable iff (!reset_n)
    $rose(flash_we_n) |-> flash_dq_oe && $stable(flash_dq_o)) // see RULE_23
    else $error("Data changed at write strobe rise");
  a_strobe_len: assert property (@(posedge mclk) disable iff (!reset_n)
    $fell(flash_we_n) |-> !flash_we_n [*2] ##1 flash_we_n) // see RULE_23
    else $error("Write strobe length wrong");
  a_no_cmd_busy: assert property (@(posedge mclk) disable iff (!reset_n)
    busy |-> flash_we_n) // see RULE_15
    else $error("Command written while busy");
  a_wait_ends: assert property (@(posedge mclk) disable iff (!reset_n)
    busy && flash_ready && cnt_q == 3'd0 |=> req_ready) // see RULE_14
    else $error("Wait not left on ready");
  a_busy_min: assert property (@(posedge mclk) disable iff (!reset_n)
    $rose(busy) |-> busy [*3]) // see RULE_14
    else $error("Wait left before busy could be seen");
  a_read_pulse: assert property (@(posedge mclk) disable iff (!reset_n)
    rd_valid |=> !rd_valid) // see RULE_10
    else $error("Read valid too long");
  a_read_no_we: assert property (@(posedge mclk) disable iff (!reset_n)
    !flash_oe_n |-> flash_we_n && !flash_dq_oe) // see RULE_08
    else $error("Read overlaps write");
  a_accel_bypass: assert property (@(posedge mclk) disable iff (!reset_n)
    accel_req |=> bypass_active) // see RULE_20
    else $error("Accel did not mark bypass");
  a_ident_reset: assert property (@(posedge mclk) disable iff (!reset_n)
    req_valid && req_ready && req.op == dbfc_pkg::DBFC_OP_RESET |=> !ident_active) // see RULE_04
    else $error("Ident not cleared by reset");

endmodule // dbfc_host

// ---- tb/dbfc_flash_model.sv ----
// Purpose: Behavioural dual-bank flash at the far side of the host sequencer
// Assumes: Writes framed by flash_ce_n low and a flash_we_n pulse
// Notes:   MAKER and PART values are arbitrary
`timescale 1ns/1ps
`include "dbfc_regs.svh"
module dbfc_flash_model #(
  parameter logic [15:0] MAKER   = 16'h00c5, // Arbitrary
  parameter logic [15:0] PART    = 16'h007e, // Arbitrary
  parameter int          BUSY_NS = 700
) (
  input  wire logic [21:0] flash_addr,
  input  wire logic [15:0] flash_dq_o,
  output logic      [15:0] flash_dq_i,
  input  wire logic        flash_ce_n,
  input  wire logic        flash_we_n,
  input  wire logic        flash_oe_n,
  input  wire logic        flash_byte_n,
  input  wire logic        protect_accel_pin,
  output logic             ready_busy_n
);
  logic [15:0] mem [int];
  logic [21:0] la;
  logic [15:0] last = 16'h0000;
  int          st [2] = '{0, 0};
  bit          id [2] = '{0, 0};
  bit          byp [2] = '{0, 0};
  bit          sec = 0;
  initial ready_busy_n = 1'b1;
  // ------------------------------------------------------------
  // Array and mode reads
  // ------------------------------------------------------------
  function automatic logic [15:0] rdv(logic [21:0] a);
    if (sec && ready_busy_n) return 16'h5e00 | a[7:0];
    if (id[a[21]]) begin
      if (a[7:0] == `DBFC_ID_MAKER) return MAKER;
      if (a[7:0] == (flash_byte_n ? `DBFC_ID_PART_W : `DBFC_ID_PART_B)) return PART;
      if (a[7:0] == (flash_byte_n ? `DBFC_ID_PROT_W : `DBFC_ID_PROT_B))
        return a[16] ? 16'(`DBFC_PROT_SET) : 16'h0000;
      return 16'h0000;
    end
    return mem.exists(int'(a)) ? mem[int'(a)] : 16'hffff;
  endfunction
  // Released bus shows the inverse of the last value
  always @* begin
    if (!flash_ce_n && !flash_oe_n) begin
      flash_dq_i = rdv(flash_addr);
      last = flash_dq_i;
    end else flash_dq_i = ~last;
  end
  // ------------------------------------------------------------
  // Command decode
  // ------------------------------------------------------------
  task automatic go();
    ready_busy_n = 1'b0;
    ready_busy_n <= #BUSY_NS 1'b1;
  endtask
  task automatic wr(logic [21:0] a, logic [7:0] d, logic [15:0] w);
    logic b;
    b = a[21];
    if (st[b] == 3) begin
      mem[int'(a)] = rdv(a) & w;
      st[b] = 0;
      go();
    end else if (byp[b]) begin
      if (st[b] == 7 && d == `DBFC_CMD_EXIT2) byp[b] = 0;
      st[b] = d == `DBFC_CMD_PROGRAM ? 3 : (d == `DBFC_CMD_IDENT ? 7 : 0);
    end else if (d == `DBFC_CMD_RESET) begin
      st[b] = 0;
      id[b] = 0;
    end else case (st[b])
      0, 4: st[b] = (a[11:0] == (flash_byte_n ? `DBFC_ADDR_U1_W : `DBFC_ADDR_U1_B)
                     && d == `DBFC_CMD_UNLOCK1) ? st[b] + 1 : 0;
      1, 5: st[b] = (a[11:0] == (flash_byte_n ? `DBFC_ADDR_U2_W : `DBFC_ADDR_U2_B)
                     && d == `DBFC_CMD_UNLOCK2) ? st[b] + 1 : 0;
      2: begin
        st[b] = 0;
        case (d)
          `DBFC_CMD_IDENT:   if (sec) st[b] = 7; else id[b] = 1;
          `DBFC_CMD_PROGRAM: st[b] = 3;
          `DBFC_CMD_BYPASS:  byp[b] = 1;
          `DBFC_CMD_ERASE:   st[b] = 4;
          `DBFC_CMD_SECURE:  sec = 1;
          default: ;
        endcase
      end
      6: begin
        st[b] = 0;
        if (d == `DBFC_CMD_CHIP) begin
          mem.delete();
          go();
        end
      end
      default: begin
        if (d == `DBFC_CMD_EXIT2) sec = 0;
        st[b] = 0;
      end
    endcase
  endtask
  always @(negedge flash_we_n) if (!flash_ce_n) la = flash_addr;
  always @(posedge flash_we_n)
    if (!flash_ce_n && ready_busy_n) wr(la, flash_dq_o[7:0], flash_dq_o);
  always @(posedge protect_accel_pin) byp = '{1, 1};
endmodule // dbfc_flash_model

// ---- tb/dbfc_host_tb.sv ----
// Purpose: Self-checking bench for the flash host sequencer
// Assumes: Inputs change at the falling edge of mclk
// Notes:   Reference memory is an integer-keyed array
`timescale 1ns/1ps
module dbfc_host_tb;
  localparam logic [15:0] MAKER = 16'h00c5;
  localparam logic [15:0] PART  = 16'h007e;
  logic mclk = 0, reset_n = 0, req_valid = 0, byte_mode = 0, accel_req = 0;
  dbfc_pkg::dbfc_req_t req = '0;
  logic req_ready, rd_valid, busy, bypass_active, ident_active, secure_active;
  logic [15:0] rd_data, flash_dq_o, flash_dq_i, got;
  logic [21:0] flash_addr, a, a0;
  logic flash_dq_oe, flash_ce_n, flash_we_n, flash_oe_n, flash_byte_n;
  logic protect_accel_pin, ready_busy_n;
  logic [31:0] seed = 32'hba235bcc, v;
  logic [15:0] rmem [int];
  int n_fail = 0, checked = 0, cyc = 0;
  bit saw_busy;
  dbfc_host dut_u (.*);
  dbfc_flash_model #(.MAKER(MAKER), .PART(PART)) model_u (.*);
  always #25 mclk = ~mclk;
  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [15:0] rexp(logic [21:0] x);
    return rmem.exists(int'(x)) ? rmem[int'(x)] : 16'hffff;
  endfunction
  task automatic conclude();
    $display("checked=%0d n_fail=%0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(logic [15:0] g, logic [15:0] e, string what);
    checked++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, g, e);
    end
  endtask
  task automatic op(dbfc_pkg::dbfc_op_t o, logic [21:0] x, logic [15:0] d);
    int n;
    n = 0;
    saw_busy = 0;
    @(negedge mclk);
    while (req_ready !== 1'b1 && n < 400) begin
      @(negedge mclk);
      n++;
    end
    req = '{op: o, bank: x[21], addr: x, data: d};
    req_valid = 1'b1;
    @(negedge mclk);
    req_valid = 1'b0;
    forever begin
      if (rd_valid === 1'b1) got = rd_data;
      if (busy === 1'b1) saw_busy = 1;
      if ((req_ready === 1'b1 && busy === 1'b0) || n > 800) break;
      @(negedge mclk);
      n++;
    end
    if (n > 800) begin
      n_fail++;
      $display("MISMATCH t=%0t request hung", $time);
    end
  endtask
  task automatic rd(logic [21:0] x, logic [15:0] e);
    got = 'x;
    op(dbfc_pkg::DBFC_OP_READ, x, 16'h0000);
    chk(got, e, "read data");
  endtask
  task automatic prg(dbfc_pkg::dbfc_op_t o, logic [21:0] x, logic [15:0] d);
    op(o, x, d);
    rmem[int'(x)] = rexp(x) & d;
    chk(16'(saw_busy), 16'h0001, "busy seen");
    rd(x, rexp(x));
  endtask
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 30000) begin
      n_fail++;
      $display("MISMATCH t=%0t timeout", $time);
      conclude();
    end
  end
  // ------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------
  initial begin
    repeat (6) @(negedge mclk);
    reset_n = 1'b1;
    rd(22'h000100, 16'hffff);
    for (int i = 0; i < 4; i++) begin
      v = xs();
      a = {i[0], 5'h00, v[15:0]};
      if (i == 0) a0 = a;
      prg(dbfc_pkg::DBFC_OP_PROGRAM, a, v[31:16]);
      prg(dbfc_pkg::DBFC_OP_PROGRAM, a, ~v[31:16] | 16'h00ff);
    end
    $display("test program end");
    op(dbfc_pkg::DBFC_OP_IDENT, 22'h200000, 16'h0000);
    chk(16'(ident_active), 16'h0001, "ident flag");
    for (int k = 0; k < 2; k++) begin
      rd(22'h200000, MAKER);
      rd(22'h200001, PART);
      rd(22'h210002, 16'h0001);
      rd(22'h200002, 16'h0000);
    end
    rd(a0, rexp(a0));
    op(dbfc_pkg::DBFC_OP_RESET, 22'h3fffff, 16'h0000);
    chk(16'(ident_active), 16'h0000, "ident flag");
    rd(22'h200000, rexp(22'h200000));
    byte_mode = 1'b1;
    op(dbfc_pkg::DBFC_OP_IDENT, 22'h000000, 16'h0000);
    rd(22'h000002, PART);
    rd(22'h010004, 16'h0001);
    op(dbfc_pkg::DBFC_OP_RESET, 22'h000000, 16'h0000);
    byte_mode = 1'b0;
    $display("test ident end");
    op(dbfc_pkg::DBFC_OP_BYP_ENTER, 22'h000000, 16'h0000);
    chk(16'(bypass_active), 16'h0001, "bypass flag");
    for (int i = 0; i < 3; i++) begin
      v = xs();
      prg(dbfc_pkg::DBFC_OP_BYP_PROGRAM, {6'h01, v[15:0]}, v[31:16]);
    end
    op(dbfc_pkg::DBFC_OP_BYP_EXIT, 22'h000000, 16'h0000);
    chk(16'(bypass_active), 16'h0000, "bypass flag");
    prg(dbfc_pkg::DBFC_OP_PROGRAM, 22'h000777, 16'h1234);
    accel_req = 1'b1;
    repeat (2) @(negedge mclk);
    chk(16'(protect_accel_pin), 16'h0001, "accel pin");
    chk(16'(bypass_active), 16'h0001, "bypass flag");
    prg(dbfc_pkg::DBFC_OP_BYP_PROGRAM, 22'h200123, 16'h8421);
    op(dbfc_pkg::DBFC_OP_BYP_EXIT, 22'h200000, 16'h0000);
    accel_req = 1'b0;
    op(dbfc_pkg::DBFC_OP_BYP_EXIT, 22'h000000, 16'h0000);
    chk(16'(bypass_active), 16'h0000, "bypass flag");
    $display("test bypass end");
    op(dbfc_pkg::DBFC_OP_SEC_ENTER, 22'h000000, 16'h0000);
    chk(16'(secure_active), 16'h0001, "secure flag");
    rd(22'h000005, 16'h5e05);
    op(dbfc_pkg::DBFC_OP_SEC_EXIT, 22'h000000, 16'h0000);
    chk(16'(secure_active), 16'h0000, "secure flag");
    rd(a0, rexp(a0));
    $display("test secure end");
    op(dbfc_pkg::DBFC_OP_CHIP_ERASE, 22'h000000, 16'h0000);
    chk(16'(saw_busy), 16'h0001, "busy seen");
    rd(a0, 16'hffff);
    $display("test erase end");
    conclude();
  end
endmodule // dbfc_host_tb
